/* File: hw/ggca_top.sv */
`include "ggca_regs.svh"
`default_nettype none
module ggca_top #(
	parameter int unsigned CONV_CYCLES =
		`GGCA_CONV_TIME_MS * `GGCA_CLK_KHZ,
	parameter int unsigned IDLE_CYCLES =
		`GGCA_SCAN_IDLE_MS * `GGCA_CLK_KHZ
) (
	// Clocks and reset
	input wire logic core_clk_in,
	input wire logic link_clk_in,
	input wire logic reset_n_in,
	// Register access from the serial engine, link clock
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic alert_response_in,
	output logic reg_busy_out,
	output logic reg_done_out,
	output logic [7:0] reg_rdata_out,
	// Dual function pin
	input wire logic alert_or_charge_done_pin_in,
	output logic alert_or_charge_done_pin_out,
	output logic alert_or_charge_done_pin_oe_out,
	// Analog front end
	input wire logic quantum_up_in,
	input wire logic quantum_dn_in,
	input wire logic [15:0] adc_value_in,
	output logic adc_run_out,
	output logic adc_temp_sel_out,
	output logic analog_shutdown_out
);

	ggca_pkg::ggca_core_st_t s_r, s_nxt;
	logic rst_s1_r, rst_n;
	logic req, we, ara;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic ctrl_wr, acc_wr, status_rd, shdn, conv_done, single_clear;
	logic step_up, step_dn, cc_force, set_any;
	logic [1:0] mode, pin_mode;
	logic [5:0] cond, set, clr;
	logic [11:0] lim, res_up, res_dn;

	// ==========================================================
	// Helpers
	function automatic logic [11:0] ggca_step(input logic [2:0] psc);
		ggca_step = `GGCA_QUANTA_PER_STEP << psc;
	endfunction : ggca_step

	function automatic logic ggca_out_band(input logic [7:0] v,
		input logic [7:0] hi, input logic [7:0] lo);
		ggca_out_band = (v > hi) || (v < lo);
	endfunction : ggca_out_band

	// ==========================================================
	// Reset release
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	ggca_link_port u_link (
		.link_clk_in(link_clk_in),
		.reset_n_in(reset_n_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_write_in(reg_write_in),
		.reg_read_in(reg_read_in),
		.alert_response_in(alert_response_in),
		.reg_busy_out(reg_busy_out),
		.reg_done_out(reg_done_out),
		.reg_rdata_out(reg_rdata_out),
		.core_clk_in(core_clk_in),
		.core_rst_n_in(rst_n),
		.core_rdata_in(rdata),
		.core_req_out(req),
		.core_write_out(we),
		.core_addr_out(addr),
		.core_wdata_out(wdata),
		.core_ara_out(ara)
	);

	// ==========================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		mode = s_r.ctrl[`GGCA_CTRL_MODE];
		pin_mode = s_r.ctrl[`GGCA_CTRL_PIN];
		shdn = s_r.ctrl[`GGCA_CTRL_SHDN];
		ctrl_wr = req && we && (addr == `GGCA_OFS_CTRL);
		acc_wr = req && we && ((addr == `GGCA_OFS_ACC_MSB) ||
			(addr == `GGCA_OFS_ACC_LSB));
		status_rd = req && !we && (addr == `GGCA_OFS_STATUS);
		conv_done = (s_r.seq == ggca_pkg::SEQ_CONV) &&
			(s_r.cnt == 32'(CONV_CYCLES - 1));
		single_clear = 1'b0;
		set = 6'h00;
		lim = ggca_step(s_r.ctrl[`GGCA_CTRL_PSC]);
		res_up = s_r.residue + 12'h001;
		res_dn = s_r.residue - 12'h001;
		step_up = 1'b0;
		step_dn = 1'b0;
		rdata = 8'h00;

		// Register read
		case (addr)
			`GGCA_OFS_STATUS: rdata = {`GGCA_CHIP_ID, 1'b0, s_r.status};
			`GGCA_OFS_CTRL: rdata = s_r.ctrl;
			`GGCA_OFS_ACC_MSB: rdata = s_r.acc[15:8];
			`GGCA_OFS_ACC_LSB: rdata = s_r.snap_valid ?
				s_r.lsb_snap : s_r.acc[7:0];
			`GGCA_OFS_CTH_HI_MSB: rdata = s_r.cth_hi[15:8];
			`GGCA_OFS_CTH_HI_LSB: rdata = s_r.cth_hi[7:0];
			`GGCA_OFS_CTH_LO_MSB: rdata = s_r.cth_lo[15:8];
			`GGCA_OFS_CTH_LO_LSB: rdata = s_r.cth_lo[7:0];
			`GGCA_OFS_VOLT_MSB: rdata = s_r.volt[15:8];
			`GGCA_OFS_VOLT_LSB: rdata = s_r.volt[7:0];
			`GGCA_OFS_VTH_HI: rdata = s_r.vth_hi;
			`GGCA_OFS_VTH_LO: rdata = s_r.vth_lo;
			`GGCA_OFS_TEMP_MSB: rdata = s_r.temp[15:8];
			`GGCA_OFS_TEMP_LSB: rdata = s_r.temp[7:0];
			`GGCA_OFS_TTH_HI: rdata = s_r.tth_hi;
			`GGCA_OFS_TTH_LO: rdata = s_r.tth_lo;
		endcase
		if (req) begin
			s_nxt.snap_valid = !we && (addr == `GGCA_OFS_ACC_MSB);
			if (!we && (addr == `GGCA_OFS_ACC_MSB)) begin
				s_nxt.lsb_snap = s_r.acc[7:0];
			end
		end

		// Conversion sequencer
		unique case (s_r.seq)
			ggca_pkg::SEQ_SLEEP: begin
				if (!shdn && (mode != `GGCA_MODE_SLEEP)) begin
					s_nxt.seq = ggca_pkg::SEQ_CONV;
					s_nxt.cnt = 32'h0000_0000;
					s_nxt.conv_temp = (mode == `GGCA_MODE_TEMP);
					s_nxt.start_mode = mode;
				end
			end
			ggca_pkg::SEQ_CONV: begin
				s_nxt.cnt = s_r.cnt + 32'h0000_0001;
				if (conv_done) begin
					s_nxt.cnt = 32'h0000_0000;
					s_nxt.seq = ggca_pkg::SEQ_SLEEP;
					if (s_r.conv_temp) begin
						s_nxt.temp = adc_value_in;
						set[`GGCA_ST_TEMP] = ggca_out_band(adc_value_in[15:8],
							s_r.tth_hi, s_r.tth_lo);
					end else begin
						s_nxt.volt = adc_value_in;
						set[`GGCA_ST_VOLT] = ggca_out_band(adc_value_in[15:8],
							s_r.vth_hi, s_r.vth_lo);
					end
					// Next mode follows the field as it stands now
					if ((mode == `GGCA_MODE_AUTO) &&
						(s_r.start_mode == `GGCA_MODE_AUTO)) begin
						if (!s_r.conv_temp) begin
							s_nxt.seq = ggca_pkg::SEQ_CONV;
							s_nxt.conv_temp = 1'b1;
						end else begin
							s_nxt.seq = ggca_pkg::SEQ_WAIT;
						end
					end else if (mode == s_r.start_mode) begin
						single_clear = 1'b1;
					end
				end
			end
			ggca_pkg::SEQ_WAIT: begin
				s_nxt.cnt = s_r.cnt + 32'h0000_0001;
				if ((mode != `GGCA_MODE_AUTO) ||
					(s_r.cnt == 32'(IDLE_CYCLES - 1))) begin
					s_nxt.seq = ggca_pkg::SEQ_SLEEP;
					s_nxt.cnt = 32'h0000_0000;
				end
			end
		endcase
		if (shdn) begin
			// Shutdown aborts any conversion in flight
			s_nxt.seq = ggca_pkg::SEQ_SLEEP;
			s_nxt.cnt = 32'h0000_0000;
		end
		if (single_clear) begin
			s_nxt.ctrl[`GGCA_CTRL_MODE] = `GGCA_MODE_SLEEP;
		end

		// Coulomb counting
		if (shdn) begin
			s_nxt.residue = 12'h000;
		end else if (quantum_up_in && !quantum_dn_in) begin
			s_nxt.residue = res_up;
			// Signed compare: a residue left from a larger prescale still steps
			if ($signed(res_up) >= $signed(lim)) begin
				s_nxt.residue = 12'h000;
				step_up = 1'b1;
			end
		end else if (quantum_dn_in && !quantum_up_in) begin
			s_nxt.residue = res_dn;
			if ($signed(res_dn) <= $signed(12'h000 - lim)) begin
				s_nxt.residue = 12'h000;
				step_dn = 1'b1;
			end
		end
		if (step_up) begin
			if (s_r.acc != `GGCA_ACC_FULL) begin
				s_nxt.acc = s_r.acc + 16'h0001;
			end
			set[`GGCA_ST_OVF] = (s_r.acc >= 16'hfffe);
		end else if (step_dn) begin
			if (s_r.acc != `GGCA_ACC_EMPTY) begin
				s_nxt.acc = s_r.acc - 16'h0001;
			end
			set[`GGCA_ST_OVF] = (s_r.acc <= 16'h0001);
		end
		s_nxt.cc_s1 = alert_or_charge_done_pin_in;
		s_nxt.cc_s2 = s_r.cc_s1;
		cc_force = (pin_mode == `GGCA_PIN_CDONE) && s_r.cc_s2;
		if (cc_force) begin
			s_nxt.acc = `GGCA_ACC_FULL;
		end

		// Host writes come last: they win over hardware updates
		if (req && we) begin
			case (addr)
				`GGCA_OFS_CTRL: s_nxt.ctrl = wdata;
				`GGCA_OFS_ACC_MSB: s_nxt.acc[15:8] = wdata;
				`GGCA_OFS_ACC_LSB: s_nxt.acc[7:0] = wdata;
				`GGCA_OFS_CTH_HI_MSB: s_nxt.cth_hi[15:8] = wdata;
				`GGCA_OFS_CTH_HI_LSB: s_nxt.cth_hi[7:0] = wdata;
				`GGCA_OFS_CTH_LO_MSB: s_nxt.cth_lo[15:8] = wdata;
				`GGCA_OFS_CTH_LO_LSB: s_nxt.cth_lo[7:0] = wdata;
				`GGCA_OFS_VTH_HI: s_nxt.vth_hi = wdata;
				`GGCA_OFS_VTH_LO: s_nxt.vth_lo = wdata;
				`GGCA_OFS_TTH_HI: s_nxt.tth_hi = wdata;
				`GGCA_OFS_TTH_LO: s_nxt.tth_lo = wdata;
				default: begin
				end
			endcase
		end

		// Status flags: a set in the clearing cycle survives
		cond = 6'h00;
		cond[`GGCA_ST_OVF] = (s_r.acc == `GGCA_ACC_FULL) ||
			(s_r.acc == `GGCA_ACC_EMPTY);
		cond[`GGCA_ST_TEMP] = ggca_out_band(s_r.temp[15:8],
			s_r.tth_hi, s_r.tth_lo);
		cond[`GGCA_ST_CHI] = s_r.acc > s_r.cth_hi;
		cond[`GGCA_ST_CLO] = s_r.acc < s_r.cth_lo;
		cond[`GGCA_ST_VOLT] = ggca_out_band(s_r.volt[15:8],
			s_r.vth_hi, s_r.vth_lo);
		s_nxt.chi_prev = cond[`GGCA_ST_CHI];
		s_nxt.clo_prev = cond[`GGCA_ST_CLO];
		set[`GGCA_ST_CHI] = cond[`GGCA_ST_CHI] && !s_r.chi_prev;
		set[`GGCA_ST_CLO] = cond[`GGCA_ST_CLO] && !s_r.clo_prev;
		clr = status_rd ? ~cond : 6'h00;
		s_nxt.status = ((s_r.status & ~clr) | set) & 6'h3e;

		// Alert: latched by events, released by alert response
		set_any = |set;
		s_nxt.alert = (pin_mode == `GGCA_PIN_ALERT) &&
			(set_any || (s_r.alert && !ara));
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.ctrl <= `GGCA_CTRL_RST;
			s_r.acc <= `GGCA_ACC_RST;
			s_r.cth_hi <= `GGCA_TH16_HI_RST;
			s_r.cth_lo <= `GGCA_TH16_LO_RST;
			s_r.vth_hi <= `GGCA_TH8_HI_RST;
			s_r.vth_lo <= `GGCA_TH8_LO_RST;
			s_r.tth_hi <= `GGCA_TH8_HI_RST;
			s_r.tth_lo <= `GGCA_TH8_LO_RST;
			s_r.seq <= ggca_pkg::SEQ_SLEEP;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign alert_or_charge_done_pin_out = 1'b0;
	assign alert_or_charge_done_pin_oe_out = s_r.alert &&
		(s_r.ctrl[`GGCA_CTRL_PIN] == `GGCA_PIN_ALERT);
	assign adc_run_out = (s_r.seq == ggca_pkg::SEQ_CONV);
	assign adc_temp_sel_out = s_r.conv_temp;
	assign analog_shutdown_out = s_r.ctrl[`GGCA_CTRL_SHDN];

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n);

	AST_SLEEP_STAYS: assert property (
		(s_r.seq == ggca_pkg::SEQ_SLEEP) && (mode == `GGCA_MODE_SLEEP)
		&& !ctrl_wr |=> (s_r.seq == ggca_pkg::SEQ_SLEEP) [*2])
		else $error("converter left sleep without a mode");
	AST_SINGLE_CLEAR: assert property (
		conv_done && (mode != `GGCA_MODE_AUTO) && (mode == s_r.start_mode)
		&& !ctrl_wr |=> (mode == `GGCA_MODE_SLEEP) &&
		(s_r.seq == ggca_pkg::SEQ_SLEEP))
		else $error("single conversion did not clear mode");
	AST_AUTO_PERSIST: assert property (
		(mode == `GGCA_MODE_AUTO) && !ctrl_wr |=> (mode == `GGCA_MODE_AUTO))
		else $error("auto mode cleared by hardware");
	AST_AUTO_ORDER: assert property (
		conv_done && !s_r.conv_temp && !shdn && !ctrl_wr &&
		(mode == `GGCA_MODE_AUTO) && (s_r.start_mode == `GGCA_MODE_AUTO)
		|=> (s_r.seq == ggca_pkg::SEQ_CONV) && s_r.conv_temp &&
		(s_r.cnt == 32'h0000_0000))
		else $error("temperature did not follow voltage");
	AST_RESULT_LOAD: assert property (
		conv_done && !s_r.conv_temp |=> s_r.volt == $past(adc_value_in))
		else $error("voltage result not loaded");
	AST_SAT_TOP: assert property (
		(s_r.acc == `GGCA_ACC_FULL) && step_up && !acc_wr
		|=> (s_r.acc == `GGCA_ACC_FULL) && s_r.status[`GGCA_ST_OVF])
		else $error("accumulator wrapped or flag missing");
	AST_STEP_UP: assert property (
		step_up && !acc_wr && !cc_force && (s_r.acc < 16'hffff)
		|=> s_r.acc == $past(s_r.acc) + 16'h0001)
		else $error("accumulator did not move by one");
	AST_CC_FULL: assert property (
		cc_force && !acc_wr |=> s_r.acc == `GGCA_ACC_FULL)
		else $error("charge done did not fill accumulator");
	AST_PIN_OFF: assert property (
		(pin_mode != `GGCA_PIN_ALERT) |-> !alert_or_charge_done_pin_oe_out
		##1 !s_r.alert)
		else $error("pin driven outside alert mode");
	AST_SHDN_HOLD: assert property (
		shdn && !acc_wr && !cc_force |=> $stable(s_r.acc) &&
		(s_r.residue == 12'h000))
		else $error("counting during shutdown");
	AST_FLAG_STICKY: assert property (
		s_r.status[`GGCA_ST_VOLT] && !status_rd
		|=> s_r.status[`GGCA_ST_VOLT])
		else $error("flag cleared without status read");
	AST_ALERT_RELEASE: assert property (
		s_r.alert && ara && !set_any |=> !s_r.alert)
		else $error("alert not released by response");

endmodule : ggca_top
`default_nettype wire

/* File: hw/ggca_regs.svh */
`ifndef GGCA_REGS_SVH
`define GGCA_REGS_SVH

// ==========================================================
// Register offsets
`define GGCA_OFS_STATUS 4'h0
`define GGCA_OFS_CTRL 4'h1
`define GGCA_OFS_ACC_MSB 4'h2
`define GGCA_OFS_ACC_LSB 4'h3
`define GGCA_OFS_CTH_HI_MSB 4'h4
`define GGCA_OFS_CTH_HI_LSB 4'h5
`define GGCA_OFS_CTH_LO_MSB 4'h6
`define GGCA_OFS_CTH_LO_LSB 4'h7
`define GGCA_OFS_VOLT_MSB 4'h8
`define GGCA_OFS_VOLT_LSB 4'h9
`define GGCA_OFS_VTH_HI 4'ha
`define GGCA_OFS_VTH_LO 4'hb
`define GGCA_OFS_TEMP_MSB 4'hc
`define GGCA_OFS_TEMP_LSB 4'hd
`define GGCA_OFS_TTH_HI 4'he
`define GGCA_OFS_TTH_LO 4'hf

// ==========================================================
// Control fields and codes
`define GGCA_CTRL_MODE 7:6
`define GGCA_CTRL_PSC 5:3
`define GGCA_CTRL_PIN 2:1
`define GGCA_CTRL_SHDN 0
`define GGCA_MODE_SLEEP 2'h0
`define GGCA_MODE_TEMP 2'h1
`define GGCA_MODE_VOLT 2'h2
`define GGCA_MODE_AUTO 2'h3
`define GGCA_PIN_OFF 2'h0
`define GGCA_PIN_CDONE 2'h1
`define GGCA_PIN_ALERT 2'h2

// ==========================================================
// Status flag positions
`define GGCA_ST_OVF 5
`define GGCA_ST_TEMP 4
`define GGCA_ST_CHI 3
`define GGCA_ST_CLO 2
`define GGCA_ST_VOLT 1
// Identification bit value is arbitrary
`define GGCA_CHIP_ID 1'h0

// ==========================================================
// Reset values and accumulator limits
`define GGCA_CTRL_RST 8'h3c
`define GGCA_ACC_RST 16'h7fff
`define GGCA_ACC_FULL 16'hffff
`define GGCA_ACC_EMPTY 16'h0000
`define GGCA_TH16_HI_RST 16'hffff
`define GGCA_TH16_LO_RST 16'h0000
`define GGCA_TH8_HI_RST 8'hff
`define GGCA_TH8_LO_RST 8'h00

// ==========================================================
// Timing and coulomb step size
`define GGCA_CLK_KHZ 250000
`define GGCA_CONV_TIME_MS 10
`define GGCA_SCAN_IDLE_MS 2000
`define GGCA_QUANTA_PER_STEP 12'h008

`endif

/* File: hw/ggca_pkg.sv */
`default_nettype none
package ggca_pkg;

	typedef enum logic [1:0] {SEQ_SLEEP, SEQ_CONV, SEQ_WAIT} ggca_seq_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [15:0] acc;
		logic [15:0] cth_hi;
		logic [15:0] cth_lo;
		logic [7:0] vth_hi;
		logic [7:0] vth_lo;
		logic [7:0] tth_hi;
		logic [7:0] tth_lo;
		logic [15:0] volt;
		logic [15:0] temp;
		logic [5:0] status;
		logic [11:0] residue;
		ggca_seq_t seq;
		logic conv_temp;
		logic [1:0] start_mode;
		logic [31:0] cnt;
		logic [7:0] lsb_snap;
		logic snap_valid;
		logic cc_s1;
		logic cc_s2;
		logic alert;
		logic chi_prev;
		logic clo_prev;
	} ggca_core_st_t;

	typedef struct packed {
		logic req_tgl;
		logic ara_tgl;
		logic ack_s1;
		logic ack_s2;
		logic ack_seen;
		logic busy;
		logic we;
		logic [3:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic done;
	} ggca_link_st_t;

	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic ara_s1;
		logic ara_s2;
		logic ara_seen;
		logic ack_tgl;
		logic [7:0] rdata_hold;
	} ggca_lcore_st_t;

endpackage : ggca_pkg
`default_nettype wire

/* File: hw/ggca_link_port.sv */
`default_nettype none
module ggca_link_port (
	// Link side
	input wire logic link_clk_in,
	input wire logic reset_n_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic alert_response_in,
	output logic reg_busy_out,
	output logic reg_done_out,
	output logic [7:0] reg_rdata_out,
	// Core side
	input wire logic core_clk_in,
	input wire logic core_rst_n_in,
	input wire logic [7:0] core_rdata_in,
	output logic core_req_out,
	output logic core_write_out,
	output logic [3:0] core_addr_out,
	output logic [7:0] core_wdata_out,
	output logic core_ara_out
);

	ggca_pkg::ggca_link_st_t l_r, l_nxt;
	ggca_pkg::ggca_lcore_st_t c_r, c_nxt;
	logic lrst_s1_r, lrst_n_r;

	// ==========================================================
	// Link domain
	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lrst_s1_r <= 1'b0;
			lrst_n_r <= 1'b0;
		end else begin
			lrst_s1_r <= 1'b1;
			lrst_n_r <= lrst_s1_r;
		end
	end

	always_comb begin
		l_nxt = l_r;
		l_nxt.done = 1'b0;
		l_nxt.ack_s1 = c_r.ack_tgl;
		l_nxt.ack_s2 = l_r.ack_s1;
		// Requests while busy are dropped; the caller must watch busy
		if (!l_r.busy && (reg_write_in || reg_read_in)) begin
			l_nxt.busy = 1'b1;
			l_nxt.we = reg_write_in;
			l_nxt.addr = reg_addr_in;
			l_nxt.wdata = reg_wdata_in;
			l_nxt.req_tgl = ~l_r.req_tgl;
		end
		if (l_r.busy && (l_r.ack_s2 != l_r.ack_seen)) begin
			l_nxt.ack_seen = l_r.ack_s2;
			l_nxt.busy = 1'b0;
			l_nxt.done = 1'b1;
			// Hold word is stable: core wrote it in the same cycle it toggled ack
			l_nxt.rdata = c_r.rdata_hold;
		end
		if (alert_response_in) begin
			l_nxt.ara_tgl = ~l_r.ara_tgl;
		end
	end

	always_ff @(posedge link_clk_in or negedge lrst_n_r) begin
		if (!lrst_n_r) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	assign reg_busy_out = l_r.busy;
	assign reg_done_out = l_r.done;
	assign reg_rdata_out = l_r.rdata;

	// ==========================================================
	// Core domain
	always_comb begin
		c_nxt = c_r;
		c_nxt.req_s1 = l_r.req_tgl;
		c_nxt.req_s2 = c_r.req_s1;
		c_nxt.ara_s1 = l_r.ara_tgl;
		c_nxt.ara_s2 = c_r.ara_s1;
		c_nxt.ara_seen = c_r.ara_s2;
		if (c_r.req_s2 != c_r.req_seen) begin
			c_nxt.req_seen = c_r.req_s2;
			c_nxt.rdata_hold = core_rdata_in;
			c_nxt.ack_tgl = ~c_r.ack_tgl;
		end
	end

	always_ff @(posedge core_clk_in or negedge core_rst_n_in) begin
		if (!core_rst_n_in) begin
			c_r <= '0;
		end else begin
			c_r <= c_nxt;
		end
	end

	assign core_req_out = c_r.req_s2 ^ c_r.req_seen;
	assign core_ara_out = c_r.ara_s2 ^ c_r.ara_seen;
	assign core_write_out = l_r.we;
	assign core_addr_out = l_r.addr;
	assign core_wdata_out = l_r.wdata;

endmodule : ggca_link_port
`default_nettype wire

/* File: sim/ggca_host_model.sv */
`default_nettype none
module ggca_host_model (
	// Link clock and answers
	input wire logic clk_in,
	input wire logic done_in,
	// Requests
	output logic [3:0] addr_out,
	output logic [7:0] wdata_out,
	output logic write_out,
	output logic read_out,
	output logic ara_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr_out = 4'h0;
		wdata_out = 8'h00;
		write_out = 1'b0;
		read_out = 1'b0;
		ara_out = 1'b0;
	end
	// ==========================================
	// One request pulse, then a bounded wait for done
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [7:0] d);
		int n;
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		write_out = w;
		read_out = !w;
		@(negedge clk_in);
		write_out = 1'b0;
		read_out = 1'b0;
		// Released lines carry garbage so a late sample shows up
		addr_out = ~a;
		wdata_out = ~d;
		n = 0;
		while (done_in !== 1'b1 && n < 20) begin
			@(negedge clk_in);
			n++;
		end
	endtask : xfer
	task automatic ara;
		@(negedge clk_in);
		ara_out = 1'b1;
		@(negedge clk_in);
		ara_out = 1'b0;
	endtask : ara
endmodule : ggca_host_model
`default_nettype wire

/* File: sim/tb.sv */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b0;
	logic up = 1'b0;
	logic dn = 1'b0;
	logic pin = 1'b0;
	logic [15:0] adc = 16'h0000;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr_s, rd_s, ara_s, busy, done, oe, run, tsel, shdn, pin_w, pin_o;
	logic [15:0] exp_q[$];
	logic [15:0] e;
	logic [31:0] seed = 32'h00014ac6;
	int miscompares = 0;
	int n_compared = 0;
	always #2 core_clk = ~core_clk;
	always #15 link_clk = ~link_clk;
	// Open-drain wire: pulled low by the device, else the charger level
	assign pin_w = oe ? pin_o : pin;
	ggca_top #(.CONV_CYCLES(80), .IDLE_CYCLES(50)) DUT (
		.core_clk_in(core_clk), .link_clk_in(link_clk),
		.reset_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_write_in(wr_s), .reg_read_in(rd_s),
		.alert_response_in(ara_s), .reg_busy_out(busy),
		.reg_done_out(done), .reg_rdata_out(rdata),
		.alert_or_charge_done_pin_in(pin_w),
		.alert_or_charge_done_pin_out(pin_o),
		.alert_or_charge_done_pin_oe_out(oe),
		.quantum_up_in(up), .quantum_dn_in(dn), .adc_value_in(adc),
		.adc_run_out(run), .adc_temp_sel_out(tsel),
		.analog_shutdown_out(shdn));
	ggca_host_model host (.clk_in(link_clk), .done_in(done),
		.addr_out(addr), .wdata_out(wdata), .write_out(wr_s),
		.read_out(rd_s), .ara_out(ara_s));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic chk(input logic [7:0] got, input logic [7:0] ex,
		input logic [7:0] m);
		n_compared++;
		if ((got & m) !== (ex & m)) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, ex);
		end
	endtask : chk
	// ==========================================
	// Result watcher: oldest note against each finished access
	always @(negedge link_clk) begin
		if (done === 1'b1) begin
			chk({7'h00, busy}, 8'h00, 8'h01);
			if (exp_q.size() == 0)
				chk(8'h01, 8'h00, 8'hff);
			else begin
				e = exp_q.pop_front();
				if (e[15:8] != 8'h00)
					chk(rdata, e[7:0], e[15:8]);
			end
		end
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		exp_q.push_back(16'h0000);
		host.xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] x,
		input logic [7:0] m = 8'hff);
		exp_q.push_back({m, x});
		host.xfer(1'b0, a, 8'h00);
	endtask : rd
	task automatic pulse(input int k, input logic u);
		repeat (k) begin
			@(negedge core_clk);
			up = u;
			dn = !u;
			@(negedge core_clk);
			up = 1'b0;
			dn = 1'b0;
		end
	endtask : pulse
	task automatic cycles(input int k);
		repeat (k) @(negedge core_clk);
	endtask : cycles
	task automatic results;
		miscompares += exp_q.size();
		$display("Compared %0d, errors %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	initial begin
		fork
			begin
				#100us;
				miscompares++;
				results();
			end
		join_none
		repeat (22) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (5) @(negedge link_clk);
		rd(4'h1, 8'h3c);
		rd(4'h2, 8'h7f);
		rd(4'h3, 8'hff);
		for (int i = 0; i < 2; i++) begin
			seed = xs(seed);
			adc = seed[15:0];
			wr(4'h1, i ? 8'h7c : 8'hbc);
			chk({7'h00, tsel}, i[7:0], 8'h01);
			chk({7'h00, run}, 8'h01, 8'h01);
			cycles(120);
			wr(i ? 4'hc : 4'h8, ~adc[15:8]);
			rd(i ? 4'hc : 4'h8, adc[15:8]);
			rd(i ? 4'hd : 4'h9, adc[7:0]);
			rd(4'h1, 8'h3c);
		end
		seed = xs(seed);
		adc = seed[15:0];
		wr(4'h1, 8'hbc);
		wr(4'h1, 8'h7c);
		cycles(250);
		rd(4'h8, adc[15:8]);
		rd(4'hc, adc[15:8]);
		rd(4'h1, 8'h3c);
		adc = ~adc;
		wr(4'h1, 8'hfc);
		cycles(200);
		rd(4'h1, 8'hfc);
		rd(4'h8, adc[15:8]);
		rd(4'hc, adc[15:8]);
		wr(4'h1, 8'h3c);
		cycles(300);
		wr(4'ha, 8'h00);
		adc = adc | 16'h8000;
		wr(4'h1, 8'hbc);
		cycles(120);
		rd(4'h0, 8'h02, 8'h02);
		chk({7'h00, oe}, 8'h01, 8'h01);
		rd(4'h0, 8'h02, 8'h02);
		wr(4'ha, 8'hff);
		rd(4'h0, 8'h02, 8'h02);
		rd(4'h0, 8'h00, 8'h02);
		host.ara();
		cycles(20);
		chk({7'h00, oe}, 8'h00, 8'h01);
		wr(4'h1, 8'h04);
		pulse(8, 1'b1);
		rd(4'h2, 8'h80);
		pulse(8, 1'b1);
		rd(4'h3, 8'h00);
		pulse(7, 1'b0);
		rd(4'h3, 8'h01);
		pulse(1, 1'b0);
		rd(4'h2, 8'h80);
		rd(4'h3, 8'h00);
		pulse(7, 1'b1);
		wr(4'h1, 8'h05);
		chk({7'h00, shdn}, 8'h01, 8'h01);
		pulse(8, 1'b1);
		wr(4'h2, 8'hff);
		wr(4'h3, 8'hfe);
		wr(4'h1, 8'h04);
		pulse(1, 1'b1);
		rd(4'h3, 8'hfe);
		pulse(16, 1'b1);
		rd(4'h2, 8'hff);
		rd(4'h3, 8'hff);
		rd(4'h0, 8'h20, 8'h20);
		chk({7'h00, oe}, 8'h01, 8'h01);
		host.ara();
		cycles(20);
		chk({7'h00, oe}, 8'h00, 8'h01);
		pulse(9, 1'b0);
		rd(4'h3, 8'hfe);
		rd(4'h0, 8'h20, 8'h20);
		rd(4'h0, 8'h00, 8'h20);
		wr(4'h1, 8'h01);
		wr(4'h2, 8'h12);
		wr(4'h3, 8'h34);
		wr(4'h1, 8'h00);
		pin = 1'b1;
		cycles(20);
		rd(4'h2, 8'h12);
		rd(4'h3, 8'h34);
		chk({7'h00, oe}, 8'h00, 8'h01);
		wr(4'h1, 8'h02);
		cycles(20);
		rd(4'h2, 8'hff);
		rd(4'h3, 8'hff);
		pin = 1'b0;
		repeat (2) @(negedge link_clk);
		results();
	end
endmodule : tb
`default_nettype wire
